// ===== sfc_pkg.sv
package sfc_pkg;

    // ------------------------------------------------------------------
    // frame geometry
    // ------------------------------------------------------------------
    localparam logic [8:0] SFC_CORE_N = 9'h120;
    localparam logic [8:0] SFC_SHB_N = 9'h140;
    localparam logic [5:0] SFC_BAND_N = 6'h20;
    localparam logic [3:0] SFC_NBANDS = 4'h9;
    localparam logic [6:0] SFC_OFS_13K2 = 7'h06;
    localparam logic [6:0] SFC_OFS_32K = 7'h50;

    // ------------------------------------------------------------------
    // sharpness tests, cross-multiplied so no divider is needed
    // ------------------------------------------------------------------
    localparam logic [3:0] SFC_PEAK_MIN = 4'h8;
    localparam logic [6:0] SFC_SHARP_PK = 7'h3E;
    localparam logic [3:0] SFC_SHARP_RS = 4'h9;
    localparam logic [6:0] SFC_NOISE_PK = 7'h1F;
    localparam logic [3:0] SFC_NOISE_RS = 4'h3;

    // ------------------------------------------------------------------
    // decision thresholds
    // ------------------------------------------------------------------
    localparam logic [3:0] SFC_IS_SWB_HM = 4'h4;
    localparam logic [3:0] SFC_IS_SWB_TR = 4'h8;
    localparam logic [3:0] SFC_IS_SWB_OT = 4'h6;
    localparam logic [3:0] SFC_IS_CHG_HM = 4'h2;
    localparam logic [3:0] SFC_IS_CHG_OT = 4'h8;
    localparam logic [4:0] SFC_LS_SWB = 5'h0A;
    localparam logic [4:0] SFC_LS_CHG_HM = 5'h05;
    localparam logic [4:0] SFC_LS_CHG_OT = 5'h14;
    localparam logic [3:0] SFC_GR_LO_G = 4'h2;
    localparam logic [3:0] SFC_GR_HI_G = 4'h5;
    localparam logic [3:0] SFC_GR_HI_P = 4'h9;
    localparam logic [3:0] SFC_PERS_MAX = 4'hC;
    localparam logic [3:0] SFC_PERS_HM = 4'h2;
    localparam logic [3:0] SFC_NOISE_CNT_MIN = 4'h4;
    localparam logic [4:0] SFC_VAR_K = 5'h05;
    localparam logic [4:0] SFC_VAR_MEAN_K = 5'h18;

    // tilt is signed with SFC_TILT_FRAC fraction bits; 5.0 in that format
    localparam int SFC_TILT_W = 8;
    localparam int SFC_TILT_FRAC = 4;
    localparam logic signed [SFC_TILT_W-1:0] SFC_TILT_NOISE_MAX = 8'sh50;

    // ------------------------------------------------------------------
    // sub-band tables
    // ------------------------------------------------------------------
    localparam logic [3:0] SFC_NB_TR = 4'h4;
    localparam logic [3:0] SFC_NB_NT = 4'hE;
    localparam logic [8:0] SFC_TR_BND [0:4] = '{9'h000, 9'h04C, 9'h098, 9'h0EC, 9'h140};
    localparam logic [8:0] SFC_NT_BND [0:14] = '{9'h000, 9'h010, 9'h028, 9'h038, 9'h050,
        9'h060, 9'h078, 9'h088, 9'h0A0, 9'h0B8, 9'h0D0, 9'h0E8, 9'h100, 9'h120, 9'h140};

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SFC_CLS_NOISE = 2'h0,
        SFC_CLS_TRANSIENT = 2'h1,
        SFC_CLS_NORMAL = 2'h2,
        SFC_CLS_HARMONIC = 2'h3
    } sfc_class_t;

    typedef struct packed {
        logic transient;
        logic prev_ext_swb;
        logic rate_32k;
        logic signed [SFC_TILT_W-1:0] tilt;
    } sfc_frame_cfg_t;

endpackage

// ===== sfc_band_stats.sv
`timescale 1ns/1ps
module sfc_band_stats
    import sfc_pkg::*;
#(
    parameter int CW = 16,
    parameter int SW = CW + 5
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic valid_i,
    input wire logic [CW-1:0] mag_i,
    output logic [SW-1:0] sum_o,
    output logic [CW-1:0] peak_o,
    output logic done_o
);

    if (SW < CW + 5) begin : g_bad_width
        $error("sfc_band_stats: sum width too narrow for one band");
    end

    logic [5:0] cnt_ff;
    logic [SW-1:0] sum_ff;
    logic [CW-1:0] peak_ff;
    logic done_ff;
    wire first = (cnt_ff == 6'h00);
    wire last = (cnt_ff == SFC_BAND_N - 6'h01);
    wire [SW-1:0] nxt_sum = (first ? '0 : sum_ff) + SW'(mag_i);
    wire [CW-1:0] nxt_peak = (first || mag_i > peak_ff) ? mag_i : peak_ff;

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || clear_i) begin
            cnt_ff <= 6'h00;
            sum_ff <= '0;
            peak_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= valid_i && last;
            if (valid_i) begin
                cnt_ff <= last ? 6'h00 : cnt_ff + 6'h01;
                sum_ff <= nxt_sum;
                peak_ff <= nxt_peak;
            end
        end
    end

    assign sum_o = sum_ff;
    assign peak_o = peak_ff;
    assign done_o = done_ff;

endmodule

// ===== sfc_classifier.sv
// What this block does
// - nine 32-coefficient sharpness bands over indices 0..287
// - sharpness is 31*peak/(sum-peak), zero sum gives zero
// - band peak is largest absolute coefficient
// - gain, mean core magnitude, band variation per frame
// - maximum sharpness is largest band peak
// - count bands with sharpness>4.5 and peak>8
// - count bands with sharpness below three
// - harmonic-count threshold from previous class and layer
// - maximum-sharpness threshold from layer and previous class
// - direct harmonic test; persistence counter up/down, max 12
// - persistence counter of two forces harmonic
// - otherwise noise or normal from counts, variation, tilt
// - class codes noise 00 transient 01 normal 10 harmonic 11
// - decided class kept as previous class
// - extension index offset 6 or 80 by rate
// - transient frames use four sub-bands to 320
// - other frames use fourteen sub-bands to 320
// - flagged transient frames skip sharpness classification
`timescale 1ns/1ps
module sfc_classifier
    import sfc_pkg::*;
#(
    parameter int CW = 16,
    parameter int GW = 2 * CW + 9
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire sfc_frame_cfg_t frame_cfg_i,
    input wire logic coef_valid_i,
    input wire logic signed [CW-1:0] coef_i,
    input wire logic [3:0] band_sel_i,
    output logic coef_ready_o,
    output logic done_o,
    output logic [1:0] class_o,
    output logic [6:0] shb_offset_o,
    output logic [GW-1:0] global_gain_o,
    output logic [3:0] sharp_cnt_o,
    output logic [3:0] noise_cnt_o,
    output logic [3:0] band_count_o,
    output logic [8:0] band_lo_o,
    output logic [8:0] band_hi_o
);

    localparam int SW = CW + 5;
    localparam int TW = CW + 9;
    localparam int VW = TW + 4;
    localparam int PW = SW + 7;

    if (CW < 5 || CW > 24 || GW < 2 * CW + 9) begin : g_bad_width
        $error("sfc_classifier: coefficient or gain width not supported");
    end

    // ------------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_CORE, ST_SHB, ST_VAR, ST_DECIDE} sfc_state_t;

    sfc_state_t state_ff;
    sfc_frame_cfg_t cfg_ff;
    logic [8:0] idx_ff;
    logic [3:0] band_ff;
    logic [3:0] vj_ff;
    logic ready_ff;
    logic done_ff;
    logic [6:0] offset_ff;
    logic [SW-1:0] sum_mem [0:8];
    logic [TW-1:0] tot_ff;
    logic [CW-1:0] kmax_ff;
    logic [3:0] sharp_ff;
    logic [3:0] noise_ff;
    logic [GW-1:0] gain_ff;
    logic [GW-1:0] gain_prev_ff;
    logic [VW-1:0] var_ff;
    logic [3:0] pers_ff;
    sfc_class_t class_ff;
    sfc_class_t prev_class_ff;
    logic [3:0] nb_ff;
    logic [8:0] lo_ff;
    logic [8:0] hi_ff;

    wire start_ok = start_i && (state_ff == ST_IDLE);
    wire take = coef_valid_i && ready_ff;
    wire take_core = take && (state_ff == ST_CORE);
    wire take_shb = take && (state_ff == ST_SHB);
    wire core_last = (idx_ff == SFC_CORE_N - 9'h001);
    wire shb_last = (idx_ff == SFC_SHB_N - 9'h001);
    wire var_last = (vj_ff == SFC_NBANDS - 4'h1);

    // ------------------------------------------------------------------
    // per-band magnitude statistics
    // ------------------------------------------------------------------
    // two's complement of the most negative code still fits unsigned CW bits
    wire [CW-1:0] mag = coef_i[CW-1] ? CW'(~coef_i + 1'b1) : CW'(coef_i);
    wire [SW-1:0] bs_sum;
    wire [CW-1:0] bs_peak;
    wire bs_done;

    sfc_band_stats #(.CW(CW), .SW(SW)) i_sfc_band_stats (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .clear_i(start_ok),
        .valid_i(take_core),
        .mag_i(mag),
        .sum_o(bs_sum),
        .peak_o(bs_peak),
        .done_o(bs_done)
    );

    // kappa > 4.5 <=> 62*peak > 9*(sum-peak); kappa < 3 <=> 31*peak < 3*(sum-peak)
    wire [SW-1:0] rest = bs_sum - SW'(bs_peak);
    wire sum_zero = (bs_sum == '0);
    wire [PW-1:0] sh_lhs = PW'(bs_peak) * PW'(SFC_SHARP_PK);
    wire [PW-1:0] sh_rhs = PW'(rest) * PW'(SFC_SHARP_RS);
    wire [PW-1:0] no_lhs = PW'(bs_peak) * PW'(SFC_NOISE_PK);
    wire [PW-1:0] no_rhs = PW'(rest) * PW'(SFC_NOISE_RS);
    wire band_sharp = !sum_zero && (sh_lhs > sh_rhs) && (bs_peak > CW'(SFC_PEAK_MIN));
    wire band_noise = sum_zero || (no_lhs < no_rhs);

    // ------------------------------------------------------------------
    // frame-wide figures
    // ------------------------------------------------------------------
    wire signed [2*CW-1:0] sq = coef_i * coef_i;
    wire [GW-1:0] nxt_gain = gain_ff + GW'($unsigned(sq));
    // deviation of band j from mean, both scaled by 288 to stay integer
    wire [TW-1:0] nine_s = TW'(sum_mem[vj_ff]) * TW'(SFC_NBANDS);
    wire [TW-1:0] dev = (nine_s >= tot_ff) ? nine_s - tot_ff : tot_ff - nine_s;
    wire [VW-1:0] nxt_var = var_ff + VW'(dev);

    // ------------------------------------------------------------------
    // decision
    // ------------------------------------------------------------------
    wire prev_hm = (prev_class_ff == SFC_CLS_HARMONIC);
    wire prev_tr = (prev_class_ff == SFC_CLS_TRANSIENT);
    wire [3:0] isharp = cfg_ff.prev_ext_swb ?
        (prev_hm ? SFC_IS_SWB_HM : (prev_tr ? SFC_IS_SWB_TR : SFC_IS_SWB_OT)) :
        (prev_hm ? SFC_IS_CHG_HM : SFC_IS_CHG_OT);
    wire [4:0] lsharp = cfg_ff.prev_ext_swb ? SFC_LS_SWB :
        (prev_hm ? SFC_LS_CHG_HM : SFC_LS_CHG_OT);
    // 0.5 < g/gp < 1.8 as 2g > gp and 5g < 9gp; a zero history never passes
    wire [GW+3:0] g_lo = (GW + 4)'(gain_ff) * (GW + 4)'(SFC_GR_LO_G);
    wire [GW+3:0] g_hi = (GW + 4)'(gain_ff) * (GW + 4)'(SFC_GR_HI_G);
    wire [GW+3:0] gp_hi = (GW + 4)'(gain_prev_ff) * (GW + 4)'(SFC_GR_HI_P);
    wire ratio_ok = (g_lo > (GW + 4)'(gain_prev_ff)) && (g_hi < gp_hi);
    wire direct_hm = (sharp_ff > isharp) && ratio_ok && (kmax_ff > CW'(lsharp));
    wire [3:0] nxt_pers = direct_hm ?
        ((pers_ff < SFC_PERS_MAX) ? pers_ff + 4'h1 : pers_ff) :
        ((pers_ff != 4'h0) ? pers_ff - 4'h1 : pers_ff);
    // S_var < 4.8*A_av scaled by 288*5 on both sides
    wire [VW+4:0] var_l = (VW + 5)'(var_ff) * (VW + 5)'(SFC_VAR_K);
    wire [VW+4:0] var_r = (VW + 5)'(tot_ff) * (VW + 5)'(SFC_VAR_MEAN_K);
    wire noise_ok = (noise_ff > SFC_NOISE_CNT_MIN) && (var_l < var_r) &&
        (cfg_ff.tilt < SFC_TILT_NOISE_MAX);
    wire sfc_class_t nxt_class = cfg_ff.transient ? SFC_CLS_TRANSIENT :
        (direct_hm || nxt_pers >= SFC_PERS_HM) ? SFC_CLS_HARMONIC :
        noise_ok ? SFC_CLS_NOISE : SFC_CLS_NORMAL;

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
            cfg_ff <= '0;
            idx_ff <= 9'h000;
            vj_ff <= 4'h0;
            ready_ff <= 1'b0;
            done_ff <= 1'b0;
            offset_ff <= SFC_OFS_13K2;
            gain_ff <= '0;
            var_ff <= '0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_ok) begin
                        cfg_ff <= frame_cfg_i;
                        offset_ff <= frame_cfg_i.rate_32k ? SFC_OFS_32K : SFC_OFS_13K2;
                        idx_ff <= 9'h000;
                        gain_ff <= '0;
                        var_ff <= '0;
                        ready_ff <= 1'b1;
                        state_ff <= ST_CORE;
                    end
                end
                ST_CORE: begin
                    if (take_core) begin
                        idx_ff <= core_last ? 9'h000 : idx_ff + 9'h001;
                        if (core_last) begin
                            state_ff <= ST_SHB;
                        end
                    end
                end
                ST_SHB: begin
                    if (take_shb) begin
                        gain_ff <= nxt_gain;
                        idx_ff <= idx_ff + 9'h001;
                        if (shb_last) begin
                            ready_ff <= 1'b0;
                            vj_ff <= 4'h0;
                            state_ff <= ST_VAR;
                        end
                    end
                end
                ST_VAR: begin
                    var_ff <= nxt_var;
                    vj_ff <= vj_ff + 4'h1;
                    if (var_last) begin
                        state_ff <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    done_ff <= 1'b1;
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // band accumulation into frame figures
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i || start_ok) begin
            band_ff <= 4'h0;
            tot_ff <= '0;
            kmax_ff <= '0;
            sharp_ff <= 4'h0;
            noise_ff <= 4'h0;
        end else if (bs_done) begin
            band_ff <= band_ff + 4'h1;
            tot_ff <= tot_ff + TW'(bs_sum);
            kmax_ff <= (bs_peak > kmax_ff) ? bs_peak : kmax_ff;
            sharp_ff <= sharp_ff + {3'h0, band_sharp};
            noise_ff <= noise_ff + {3'h0, band_noise};
        end
    end

    // band sums are data only, so they carry no reset
    always_ff @(posedge clk_sys_i) begin
        if (bs_done) begin
            sum_mem[band_ff] <= bs_sum;
        end
    end

    // ------------------------------------------------------------------
    // history kept across frames
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            prev_class_ff <= SFC_CLS_NORMAL;
            class_ff <= SFC_CLS_NORMAL;
            gain_prev_ff <= '0;
            pers_ff <= 4'h0;
        end else if (state_ff == ST_DECIDE) begin
            class_ff <= nxt_class;
            prev_class_ff <= nxt_class;
            gain_prev_ff <= gain_ff;
            // a flagged transient frame leaves persistence untouched
            if (!cfg_ff.transient) begin
                pers_ff <= nxt_pers;
            end
        end
    end

    // ------------------------------------------------------------------
    // sub-band table lookup for the last decided frame
    // ------------------------------------------------------------------
    wire use_tr = (class_ff == SFC_CLS_TRANSIENT);
    wire sel_ok = use_tr ? (band_sel_i < SFC_NB_TR) : (band_sel_i < SFC_NB_NT);
    wire [3:0] sel_hi = band_sel_i + 4'h1;
    wire [8:0] nxt_lo = !sel_ok ? 9'h000 :
        (use_tr ? SFC_TR_BND[band_sel_i[2:0]] : SFC_NT_BND[band_sel_i]);
    wire [8:0] nxt_hi = !sel_ok ? 9'h000 :
        (use_tr ? SFC_TR_BND[sel_hi[2:0]] : SFC_NT_BND[sel_hi]);

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            nb_ff <= SFC_NB_NT;
            lo_ff <= 9'h000;
            hi_ff <= 9'h000;
        end else begin
            nb_ff <= use_tr ? SFC_NB_TR : SFC_NB_NT;
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
        end
    end
    assign coef_ready_o = ready_ff;
    assign done_o = done_ff;
    assign class_o = class_ff;
    assign shb_offset_o = offset_ff;
    assign global_gain_o = gain_ff;
    assign sharp_cnt_o = sharp_ff;
    assign noise_cnt_o = noise_ff;
    assign band_count_o = nb_ff;
    assign band_lo_o = lo_ff;
    assign band_hi_o = hi_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_transient_code;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        done_o && cfg_ff.transient |-> class_o == SFC_CLS_TRANSIENT;
    endproperty
    a_transient_code: assert property (p_transient_code)
        else $error("transient frame not coded as transient");
    property p_pers_hm;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        done_o && !cfg_ff.transient && pers_ff >= 4'h2 |-> class_o == SFC_CLS_HARMONIC;
    endproperty
    a_pers_hm: assert property (p_pers_hm)
        else $error("persistence two or more but frame not harmonic");
    property p_pers_max;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        pers_ff <= 4'hC;
    endproperty
    a_pers_max: assert property (p_pers_max)
        else $error("persistence counter above twelve");
    property p_pers_step;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        done_o && !cfg_ff.transient && $past(direct_hm) && $past(pers_ff) < 4'hC
            |-> pers_ff == $past(pers_ff) + 4'h1;
    endproperty
    a_pers_step: assert property (p_pers_step)
        else $error("persistence counter did not increment on harmonic frame");
    property p_done_pulse;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        done_o |=> !done_o [*2];
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");
    property p_prev_class;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        prev_class_ff == class_o && (done_o || $stable(prev_class_ff));
    endproperty
    a_prev_class: assert property (p_prev_class)
        else $error("previous class not the decided class or changed between frames");
    property p_noise_needs_count;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        done_o && class_o == SFC_CLS_NOISE |->
            noise_cnt_o > 4'h4 && cfg_ff.tilt < SFC_TILT_NOISE_MAX;
    endproperty
    a_noise_needs_count: assert property (p_noise_needs_count)
        else $error("noise class with too few noise bands or high tilt");
    property p_offset;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        done_o |-> shb_offset_o == (cfg_ff.rate_32k ? 7'h50 : 7'h06);
    endproperty
    a_offset: assert property (p_offset)
        else $error("extension offset does not match rate");
    property p_reset_state;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> pers_ff == 4'h0 && prev_class_ff == SFC_CLS_NORMAL &&
            gain_prev_ff == '0;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("history not cleared by reset");
    property p_tr_table;
        @(posedge clk_sys_i) disable iff (!resetn_i)
        class_o == SFC_CLS_TRANSIENT && band_sel_i == 4'h3 |=> band_hi_o == 9'h140;
    endproperty
    a_tr_table: assert property (p_tr_table)
        else $error("transient last band does not end at 320");

endmodule

// ===== sfc_upstream_model.sv
`timescale 1ns/1ps
module sfc_upstream_model
    import sfc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic go_i,
    input wire logic slow_i,
    input wire logic lump_i,
    input wire logic [15:0] peak_i,
    input wire logic [15:0] base_i,
    input wire logic [15:0] ext_i,
    input wire logic coef_ready_i,
    output logic coef_valid_o,
    output logic [15:0] coef_o
);
    logic [9:0] idx_ff;
    logic act_ff;
    logic gap_ff;
    logic tog_ff;
    logic fire;
    logic [15:0] val;
    logic lead;
    // each 32-beat core band leads with its peak, then the extension beats
    // lump mode fills band zero with the peak so the bands differ in mean
    assign lead = lump_i ? (idx_ff < 10'h020) : (idx_ff[4:0] == 5'h00);
    assign val = (idx_ff >= 10'h120) ? ext_i : lead ? peak_i : base_i;
    assign fire = coef_valid_o && coef_ready_i;
    assign coef_valid_o = act_ff && !gap_ff;
    // idle bus toggles so a stale sample can never pass for data
    assign coef_o = coef_valid_o ? val : (tog_ff ? 16'hA5A5 : 16'h5A5A);
    always_ff @(posedge clk_sys_i) begin
        tog_ff <= !tog_ff && resetn_i;
        gap_ff <= slow_i && fire && resetn_i;
        if (!resetn_i) begin
            act_ff <= 1'b0;
            idx_ff <= 10'h000;
        end else if (go_i) begin
            act_ff <= 1'b1;
            idx_ff <= 10'h000;
        end else if (fire) begin
            idx_ff <= idx_ff + 10'h001;
            act_ff <= (idx_ff != 10'h25F);
        end
    end
endmodule

// ===== sfc_classifier_test.sv
`timescale 1ns/1ps
module sfc_classifier_test
    import sfc_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic start_i = 1'b0;
    logic slow = 1'b0;
    logic lump = 1'b0;
    logic [15:0] pk = 16'h0000;
    logic [15:0] bs = 16'h0000;
    logic [15:0] ex = 16'h0000;
    logic [3:0] bsel = 4'h0;
    sfc_frame_cfg_t cfg = '0;
    logic cv;
    logic [15:0] coef;
    logic rdy;
    logic done;
    logic [1:0] cls;
    logic [6:0] ofs;
    logic [40:0] gain;
    logic [3:0] shc;
    logic [3:0] nsc;
    logic [3:0] bcnt;
    logic [8:0] lo;
    logic [8:0] hi;
    int bad_count = 0;
    int num_checks = 0;
    int fno = 0;

    always #12.5 clk_sys_i = !clk_sys_i;

    sfc_upstream_model i_sfc_upstream_model (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .go_i(start_i), .slow_i(slow), .lump_i(lump), .peak_i(pk), .base_i(bs), .ext_i(ex),
        .coef_ready_i(rdy), .coef_valid_o(cv), .coef_o(coef));
    sfc_classifier i_sfc_classifier (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .start_i(start_i), .frame_cfg_i(cfg), .coef_valid_i(cv), .coef_i(coef),
        .band_sel_i(bsel), .coef_ready_o(rdy), .done_o(done), .class_o(cls),
        .shb_offset_o(ofs), .global_gain_o(gain), .sharp_cnt_o(shc), .noise_cnt_o(nsc),
        .band_count_o(bcnt), .band_lo_o(lo), .band_hi_o(hi));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [40:0] e, input logic [40:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    function automatic logic [8:0] bnd(input logic tr, input int k);
        return tr ? SFC_TR_BND[k] : SFC_NT_BND[k];
    endfunction

    // m is {slow, transient, prev_ext_swb, rate_32k}
    task automatic frm(input logic [3:0] m, input logic signed [7:0] tl, input logic [15:0] p,
        input logic [15:0] b, input logic [15:0] e, input logic [1:0] c, input logic [3:0] s,
        input logic [3:0] z);
        int n;
        @(negedge clk_sys_i);
        {slow, cfg.transient, cfg.prev_ext_swb, cfg.rate_32k} = m;
        cfg.tilt = tl;
        pk = p;
        bs = b;
        ex = e;
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
        chk("ready", 41'h1, 41'(rdy));
        n = 0;
        while (done !== 1'b1 && n < 1500) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk("done", 41'h1, 41'(done));
        chk("ready", 41'h0, 41'(rdy));
        chk("class", 41'(c), 41'(cls));
        chk("offset", m[0] ? 41'h50 : 41'h06, 41'(ofs));
        chk("gain", 41'(e) * 41'(e) * 41'h140, gain);
        if (!m[2]) begin
            chk("sharp", 41'(s), 41'(shc));
            chk("noise", 41'(z), 41'(nsc));
        end
        @(negedge clk_sys_i);
        chk("pulse", 41'h0, 41'(done));
        chk("nbands", m[2] ? 41'h4 : 41'hE, 41'(bcnt));
        for (int j = 0; j < 15; j++) begin
            bsel = 4'(j);
            @(negedge clk_sys_i);
            n = (j < (m[2] ? 4 : 14)) ? 1 : 0;
            chk("lo", n ? 41'(bnd(m[2], j)) : 41'h0, 41'(lo));
            chk("hi", n ? 41'(bnd(m[2], j + 1)) : 41'h0, 41'(hi));
        end
        fno++;
        $display("frame %0d finished", fno);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        chk("rst class", 41'h2, 41'(cls));
        chk("rst offset", 41'h6, 41'(ofs));
        chk("rst gain", 41'h0, gain);
        // persistence: first frame has no gain history so the direct test fails
        frm(4'h3, 8'sh10, 16'hFF9C, 16'h0001, 16'h000A, 2'h2, 4'h9, 4'h0);
        frm(4'h3, 8'sh10, 16'hFF9C, 16'h0001, 16'h000A, 2'h3, 4'h9, 4'h0);
        frm(4'h3, 8'sh10, 16'hFF9C, 16'h0001, 16'h000A, 2'h3, 4'h9, 4'h0);
        frm(4'hB, 8'sh10, 16'h0064, 16'h0001, 16'h000A, 2'h3, 4'h9, 4'h0);
        frm(4'h2, 8'sh10, 16'h0001, 16'h0001, 16'h000A, 2'h3, 4'h0, 4'h9);
        frm(4'h2, 8'sh10, 16'h0001, 16'h0001, 16'h000A, 2'h0, 4'h0, 4'h9);
        frm(4'hA, 8'sh50, 16'h0001, 16'h0001, 16'h000A, 2'h2, 4'h0, 4'h9);
        frm(4'h6, 8'sh10, 16'hFF9C, 16'h0001, 16'h000A, 2'h1, 4'h0, 4'h0);
        frm(4'h3, 8'sh10, 16'hFF9C, 16'h0001, 16'h000A, 2'h3, 4'h9, 4'h0);
        frm(4'h1, 8'sh10, 16'h0009, 16'h0001, 16'h000A, 2'h3, 4'h9, 4'h0);
        frm(4'h1, 8'sh10, 16'h0001, 16'h0001, 16'h000A, 2'h0, 4'h0, 4'h9);
        frm(4'h1, 8'sh10, 16'h0001, 16'h0001, 16'h000A, 2'h0, 4'h0, 4'h9);
        frm(4'h1, 8'sh10, 16'h0014, 16'h0001, 16'h000A, 2'h2, 4'h9, 4'h0);
        frm(4'h1, 8'sh10, 16'h0015, 16'h0001, 16'h000A, 2'h3, 4'h9, 4'h0);
        frm(4'h3, 8'sh10, 16'h0064, 16'h0001, 16'h000E, 2'h2, 4'h9, 4'h0);
        frm(4'h3, 8'sh10, 16'h0009, 16'h0002, 16'h000E, 2'h2, 4'h0, 4'h0);
        // uneven band means: variation too large for noise
        lump = 1'b1;
        frm(4'h2, 8'sh10, 16'h0064, 16'h0001, 16'h000A, 2'h2, 4'h0, 4'h9);
        tally_and_finish();
    end

    // the run needs about 12000 cycles
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
